// [hw/pujog_jog_output.sv]
/*
  Jog output block: register port, input checks, run control, pulse and
  direction drive, fault reporting and a level interrupt.
  Assumes a 125 MHz clock, asynchronous slot description inputs and a
  register master that never waits.
// Overview of operation
// - The active flag rises once run is requested and stays while it stays.
// - Dropping the run request clears active, fault and the fault code.
// - The slot index addresses modules 0 to 31 counting every module.
// - A slot that holds no pulse-output unit faults and drives nothing.
// - Axis 1 to 4 is accepted only if the selected unit has that axis.
// - A positive jog frequency pulses forward with direction low.
// - A negative jog frequency pulses backward with direction high.
// - A zero jog frequency stops the pulses on the selected axis.
// - Frequency is limited to 200000 on two-axis and 100000 on four-axis.
// - Any bad input or bad execution sets fault with a cause code.
// - A fault found while starting sets fault and records its cause.
*/
`timescale 1ns/1ps
`default_nettype none

module pujog_jog_output (
  input  wire logic                               ref_clk_in,
  input  wire logic                               rst_n_in,
  input  wire logic [pujog_pkg::PUJOG_ADDR_W-1:0] addr_in,
  input  wire logic [31:0]                        wr_data_in,
  input  wire logic                               wr_en_in,
  input  wire logic                               rd_en_in,
  output logic      [31:0]                        rd_data_out,
  input  wire logic [pujog_pkg::PUJOG_SLOTS-1:0]  slot_is_pu_in,
  input  wire logic [pujog_pkg::PUJOG_SLOTS-1:0]  slot_four_axis_in,
  output logic      [pujog_pkg::PUJOG_AXES-1:0]   pulse_out,
  output logic      [pujog_pkg::PUJOG_AXES-1:0]   dir_out,
  output logic      [4:0]                         slot_sel_out,
  output logic                                    active_flag_out,
  output logic                                    fault_flag_out,
  output logic      [7:0]                         fault_code_out,
  output logic                                    irq_out
);

  import pujog_pkg::*;

  logic [1:0]             rst_sync;
  logic                   rst_n;
  logic [PUJOG_SLOTS-1:0] pu_meta;
  logic [PUJOG_SLOTS-1:0] pu_sync;
  logic [PUJOG_SLOTS-1:0] four_meta;
  logic [PUJOG_SLOTS-1:0] four_sync;
  logic                   run_req;
  logic [7:0]             slot_index;
  logic [15:0]            axis_select;
  logic [31:0]            jog_frequency;
  logic [PUJOG_IRQ_W-1:0] irq_status;
  logic [PUJOG_IRQ_W-1:0] irq_mask;
  logic [PUJOG_IRQ_W-1:0] irq_event;
  pujog_state_e           state;
  pujog_state_e           next_state;
  logic [7:0]             cause;
  logic                   inputs_ok;
  logic                   slot_ok;
  logic                   unit_is_pu;
  logic                   unit_four;
  logic                   axis_ok;
  logic                   freq_ok;
  logic [31:0]            freq_mag;
  logic [31:0]            freq_max;
  logic [15:0]            axis_max;
  logic [1:0]             axis_idx;
  logic                   checking;
  logic                   gen_en;
  logic                   wave;

  // Reset is taken at once and released through two flip-flops.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // Slot descriptions come from outside and pass two flip-flops.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pu_meta   <= '0;
      pu_sync   <= '0;
      four_meta <= '0;
      four_sync <= '0;
    end else begin
      pu_meta   <= slot_is_pu_in;
      pu_sync   <= pu_meta;
      four_meta <= slot_four_axis_in;
      four_sync <= four_meta;
    end
  end

  // Software-written command registers.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      run_req       <= 1'b0;
      slot_index    <= PUJOG_SLOT_RST;
      axis_select   <= PUJOG_AXIS_RST;
      jog_frequency <= PUJOG_FREQ_RST;
    end else if (wr_en_in) begin
      case (addr_in)
        PUJOG_OFS_CTRL: run_req       <= wr_data_in[PUJOG_CTRL_RUN_BIT];
        PUJOG_OFS_SLOT: slot_index    <= wr_data_in[7:0];
        PUJOG_OFS_AXIS: axis_select   <= wr_data_in[15:0];
        PUJOG_OFS_FREQ: jog_frequency <= wr_data_in;
        default:        run_req       <= run_req;
      endcase
    end
  end

  // Interrupt mask register.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= '0;
    end else if (wr_en_in && addr_in == PUJOG_OFS_IRQ_MASK) begin
      irq_mask <= wr_data_in[PUJOG_IRQ_W-1:0];
    end
  end

  // Slot lookup; only the low five bits index once the range is checked.
  assign slot_ok    = slot_index <= PUJOG_SLOT_MAX;
  assign unit_is_pu = pu_sync[slot_index[4:0]];
  assign unit_four  = four_sync[slot_index[4:0]];

  // Axis range depends on the unit variant.
  assign axis_max = unit_four ? PUJOG_AXIS_MAX_FOUR : PUJOG_AXIS_MAX_TWO;
  assign axis_ok  = (axis_select >= PUJOG_AXIS_MIN) &&
                    (axis_select <= axis_max);
  assign axis_idx = axis_select[1:0] - 2'h1;

  // Magnitude is taken unsigned so the most negative value stays large.
  assign freq_mag = jog_frequency[31] ? (~jog_frequency + 32'h00000001)
                                      : jog_frequency;
  assign freq_max = unit_four ? PUJOG_FREQ_MAX_FOUR : PUJOG_FREQ_MAX_TWO;
  assign freq_ok  = freq_mag <= freq_max;

  // Cause priority follows addressing order: slot, unit, axis, value.
  always_comb begin
    if (!slot_ok) begin
      cause = PUJOG_FC_SLOT;
    end else if (!unit_is_pu) begin
      cause = PUJOG_FC_NOT_PU;
    end else if (!axis_ok) begin
      cause = PUJOG_FC_AXIS;
    end else if (!freq_ok) begin
      cause = PUJOG_FC_FREQ;
    end else begin
      cause = PUJOG_FC_NONE;
    end
  end

  assign inputs_ok = cause == PUJOG_FC_NONE;
  assign checking  = (state == PUJOG_START) || (state == PUJOG_RUN);

  // Run control; dropping the request always wins and returns to idle.
  always_comb begin
    case (state)
      PUJOG_IDLE:  next_state = run_req ? PUJOG_START : PUJOG_IDLE;
      PUJOG_START, PUJOG_RUN: begin
        if (!run_req) begin
          next_state = PUJOG_IDLE;
        end else if (inputs_ok) begin
          next_state = PUJOG_RUN;
        end else begin
          next_state = PUJOG_FAULT;
        end
      end
      PUJOG_FAULT: next_state = run_req ? PUJOG_FAULT : PUJOG_IDLE;
      default:     next_state = PUJOG_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= PUJOG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Fault code holds the first cause found and clears with the request.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fault_code_out <= PUJOG_FC_NONE;
    end else if (!run_req) begin
      fault_code_out <= PUJOG_FC_NONE;
    end else if (checking && !inputs_ok) begin
      fault_code_out <= cause;
    end
  end

  // Flags decode straight from the state register.
  assign active_flag_out = state != PUJOG_IDLE;
  assign fault_flag_out  = state == PUJOG_FAULT;

  // The generator runs only with valid inputs and a nonzero frequency.
  assign gen_en = (state == PUJOG_RUN) && run_req && inputs_ok &&
                  (jog_frequency != PUJOG_FREQ_RST);

  pujog_pulse_gen u_gen (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n),
    .enable_in  (gen_en),
    .rate_in    (freq_mag[PUJOG_RATE_W-1:0]),
    .wave_out   (wave)
  );

  // Pulse and direction drive for each axis; only the selected one moves.
  genvar gi;
  generate
    for (gi = 0; gi < PUJOG_AXES; gi++) begin : g_axis
      always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          pulse_out[gi] <= 1'b0;
          dir_out[gi]   <= 1'b0;
        end else begin
          pulse_out[gi] <= gen_en && (axis_idx == gi) && wave;
          dir_out[gi]   <= gen_en && (axis_idx == gi) &&
                           jog_frequency[31];
        end
      end
    end
  endgenerate

  // Selected slot is presented to the expansion bus.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      slot_sel_out <= '0;
    end else begin
      slot_sel_out <= slot_index[4:0];
    end
  end

  // Interrupt events: run started, fault raised, run ended.
  assign irq_event[PUJOG_IRQ_START_BIT] = (state == PUJOG_START) &&
                                          run_req && inputs_ok;
  assign irq_event[PUJOG_IRQ_FAULT_BIT] = checking && run_req && !inputs_ok;
  assign irq_event[PUJOG_IRQ_STOP_BIT]  = (state != PUJOG_IDLE) && !run_req;

  // Sticky status cleared by reading it; a new event wins over the clear.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else if (rd_en_in && addr_in == PUJOG_OFS_IRQ_STAT) begin
      irq_status <= irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  assign irq_out = |(irq_status & irq_mask);

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_out <= '0;
    end else if (!rd_en_in) begin
      rd_data_out <= '0;
    end else begin
      case (addr_in)
        PUJOG_OFS_CTRL:     rd_data_out <= {31'h00000000, run_req};
        PUJOG_OFS_SLOT:     rd_data_out <= {24'h000000, slot_index};
        PUJOG_OFS_AXIS:     rd_data_out <= {16'h0000, axis_select};
        PUJOG_OFS_FREQ:     rd_data_out <= jog_frequency;
        PUJOG_OFS_STAT: begin
          rd_data_out <= '0;
          rd_data_out[PUJOG_STAT_ACTIVE_BIT] <= active_flag_out;
          rd_data_out[PUJOG_STAT_FAULT_BIT]  <= fault_flag_out;
          rd_data_out[PUJOG_STAT_CODE_LSB +: 8] <= fault_code_out;
        end
        PUJOG_OFS_IRQ_STAT: rd_data_out <= {29'h00000000, irq_status};
        PUJOG_OFS_IRQ_MASK: rd_data_out <= {29'h00000000, irq_mask};
        default:            rd_data_out <= '0;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  // A new request makes the block active on the next edge.
  property p_active_rise;
    $rose(run_req) |=> active_flag_out;
  endproperty
  a_active_rise: assert property (p_active_rise)
    else $error("Active did not follow run request.");

  // Active stays as long as the request stays.
  property p_active_hold;
    run_req [*2] |-> active_flag_out;
  endproperty
  a_active_hold: assert property (p_active_hold)
    else $error("Active dropped while run held.");

  // Dropping the request clears every status output.
  property p_clear_on_drop;
    !run_req |=> !active_flag_out && !fault_flag_out &&
                 fault_code_out == PUJOG_FC_NONE;
  endproperty
  a_clear_on_drop: assert property (p_clear_on_drop)
    else $error("Status not cleared after run dropped.");

  // A slot without a pulse unit faults and never pulses.
  property p_not_pu;
    (state == PUJOG_START) && run_req && slot_ok && !unit_is_pu |=>
      fault_flag_out && fault_code_out == PUJOG_FC_NOT_PU ##1
      pulse_out == '0;
  endproperty
  a_not_pu: assert property (p_not_pu)
    else $error("Non pulse unit slot did not fault.");

  // An axis the unit lacks is reported with the axis code.
  property p_bad_axis;
    checking && run_req && slot_ok && unit_is_pu && !axis_ok |=>
      fault_flag_out && fault_code_out == PUJOG_FC_AXIS;
  endproperty
  a_bad_axis: assert property (p_bad_axis)
    else $error("Missing axis not reported.");

  // Positive frequency keeps every direction output low.
  property p_dir_pos;
    !jog_frequency[31] |=> dir_out == '0;
  endproperty
  a_dir_pos: assert property (p_dir_pos)
    else $error("Direction high for positive frequency.");

  // Negative frequency while running drives the direction output high.
  property p_dir_neg;
    gen_en && jog_frequency[31] |=> $countones(dir_out) == 1;
  endproperty
  a_dir_neg: assert property (p_dir_neg)
    else $error("Direction not driven for negative frequency.");

  // Zero frequency gives no pulses.
  property p_zero_stop;
    jog_frequency == PUJOG_FREQ_RST |=> pulse_out == '0;
  endproperty
  a_zero_stop: assert property (p_zero_stop)
    else $error("Pulses present at zero frequency.");

  // Frequency beyond the variant limit is reported with the value code.
  property p_freq_limit;
    checking && run_req && slot_ok && unit_is_pu && axis_ok &&
    (freq_mag > freq_max) |=> fault_code_out == PUJOG_FC_FREQ;
  endproperty
  a_freq_limit: assert property (p_freq_limit)
    else $error("Out of range frequency not reported.");

  // Any fault at startup enters the fault state with a nonzero code.
  property p_start_fault;
    (state == PUJOG_START) && run_req && !inputs_ok |=>
      fault_flag_out && fault_code_out != PUJOG_FC_NONE;
  endproperty
  a_start_fault: assert property (p_start_fault)
    else $error("Startup fault not flagged.");

endmodule : pujog_jog_output
`default_nettype wire

// [hw/pujog_pkg.sv]
/*
  Constants and types shared by the jog pulse-output block: register
  offsets, field positions, reset values, limits, fault codes, states.
  Assumes a single 125 MHz system clock.
*/
package pujog_pkg;

  // Clock rate and derived accumulator modulus, both in hertz.
  localparam int unsigned PUJOG_CLK_MHZ = 125;
  localparam int unsigned PUJOG_CLK_HZ  = PUJOG_CLK_MHZ * 1000000;
  localparam int          PUJOG_ACC_W   = 28;
  localparam logic [PUJOG_ACC_W-1:0] PUJOG_ACC_MOD =
    PUJOG_CLK_HZ[PUJOG_ACC_W-1:0];

  // Sizes of the addressed system.
  localparam int PUJOG_SLOTS  = 32;
  localparam int PUJOG_AXES   = 4;
  localparam int PUJOG_RATE_W = 18;
  localparam int PUJOG_ADDR_W = 8;

  // Register offsets (byte addresses).
  localparam logic [7:0] PUJOG_OFS_CTRL     = 8'h00;
  localparam logic [7:0] PUJOG_OFS_SLOT     = 8'h04;
  localparam logic [7:0] PUJOG_OFS_AXIS     = 8'h08;
  localparam logic [7:0] PUJOG_OFS_FREQ     = 8'h0C;
  localparam logic [7:0] PUJOG_OFS_STAT     = 8'h10;
  localparam logic [7:0] PUJOG_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] PUJOG_OFS_IRQ_MASK = 8'h18;

  // Field positions.
  localparam int PUJOG_CTRL_RUN_BIT    = 0;
  localparam int PUJOG_STAT_ACTIVE_BIT = 0;
  localparam int PUJOG_STAT_FAULT_BIT  = 1;
  localparam int PUJOG_STAT_CODE_LSB   = 8;
  localparam int PUJOG_IRQ_START_BIT   = 0;
  localparam int PUJOG_IRQ_FAULT_BIT   = 1;
  localparam int PUJOG_IRQ_STOP_BIT    = 2;
  localparam int PUJOG_IRQ_W           = 3;

  // Input limits and reset values.
  localparam logic [7:0]  PUJOG_SLOT_MAX       = 8'h1F;
  localparam logic [7:0]  PUJOG_SLOT_RST       = 8'h00;
  localparam logic [15:0] PUJOG_AXIS_MIN       = 16'h0001;
  localparam logic [15:0] PUJOG_AXIS_MAX_TWO   = 16'h0002;
  localparam logic [15:0] PUJOG_AXIS_MAX_FOUR  = 16'h0004;
  localparam logic [15:0] PUJOG_AXIS_RST       = 16'h0001;
  localparam logic [31:0] PUJOG_FREQ_MAX_TWO   = 32'h00030D40;
  localparam logic [31:0] PUJOG_FREQ_MAX_FOUR  = 32'h000186A0;
  localparam logic [31:0] PUJOG_FREQ_RST       = 32'h00000000;

  // Fault codes.
  localparam logic [7:0] PUJOG_FC_NONE   = 8'h00;
  localparam logic [7:0] PUJOG_FC_SLOT   = 8'h01;
  localparam logic [7:0] PUJOG_FC_NOT_PU = 8'h02;
  localparam logic [7:0] PUJOG_FC_AXIS   = 8'h03;
  localparam logic [7:0] PUJOG_FC_FREQ   = 8'h04;

  // Control states.
  typedef enum logic [3:0] {
    PUJOG_IDLE  = 4'b0001,
    PUJOG_START = 4'b0010,
    PUJOG_RUN   = 4'b0100,
    PUJOG_FAULT = 4'b1000
  } pujog_state_e;

endpackage : pujog_pkg

// [hw/pujog_pulse_gen.sv]
/*
  Square-wave generator whose output frequency in hertz equals the rate
  input. Assumes the synchronous reset copy and clock of the main block.
*/
`timescale 1ns/1ps
`default_nettype none

module pujog_pulse_gen (
  input  wire logic                               ref_clk_in,
  input  wire logic                               rst_n_in,
  input  wire logic                               enable_in,
  input  wire logic [pujog_pkg::PUJOG_RATE_W-1:0] rate_in,
  output logic                                    wave_out
);

  import pujog_pkg::*;

  logic [PUJOG_ACC_W-1:0] acc;
  logic [PUJOG_ACC_W-1:0] step;
  logic [PUJOG_ACC_W-1:0] sum;

  // Two edges per period, so the accumulator advances by twice the rate.
  assign step = {{(PUJOG_ACC_W-PUJOG_RATE_W-1){1'b0}}, rate_in, 1'b0};
  assign sum  = acc + step;

  // Each wrap of the accumulator toggles the wave; the remainder is kept
  // so the long-run rate is exact.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc      <= '0;
      wave_out <= 1'b0;
    end else if (!enable_in) begin
      acc      <= '0;
      wave_out <= 1'b0;
    end else if (sum >= PUJOG_ACC_MOD) begin
      acc      <= sum - PUJOG_ACC_MOD;
      wave_out <= ~wave_out;
    end else begin
      acc      <= sum;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  // The wave is held low whenever the generator is switched off.
  property p_wave_idle;
    !enable_in |=> !wave_out;
  endproperty
  a_wave_idle: assert property (p_wave_idle)
    else $error("Wave not low after disable.");

endmodule : pujog_pulse_gen
`default_nettype wire

// [testbench/pujog_bus_model.sv]
/*
  Expansion bus model beside the jog block: presents the slot map and
  counts rising pulse edges on all axes.
  Assumes the bench clock and the raw active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pujog_bus_model #(
  parameter logic [31:0] PU_MAP   = 32'h000000F0,
  parameter logic [31:0] FOUR_MAP = 32'h00000030
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clr_in,
  input  wire logic [3:0]  pulse_in,
  output logic      [31:0] slot_is_pu_out,
  output logic      [31:0] slot_four_axis_out,
  output logic      [15:0] edge_cnt_out
);
  logic [3:0] last_pulse;

  // Every position counts, whatever sits there, 32 positions in all.
  assign slot_is_pu_out     = PU_MAP;
  assign slot_four_axis_out = FOUR_MAP;

  // Counts rising edges on any axis; the bench clears it between windows.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_pulse   <= 4'h0;
      edge_cnt_out <= 16'h0000;
    end else begin
      last_pulse <= pulse_in;
      if (clr_in) begin
        edge_cnt_out <= 16'h0000;
      end else if (|(pulse_in & ~last_pulse)) begin
        edge_cnt_out <= edge_cnt_out + 16'h0001;
      end
    end
  end
endmodule : pujog_bus_model

`default_nettype wire

// [testbench/tb_top.sv]
/*
  Self-checking bench for the jog output block: register port, runs,
  faults, direction, pulse rate and interrupt.
  Assumes the bus model presents slots 4,5 as four-axis units, 6,7 as
  two-axis units and all other slots as other modules.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))

module tb_top;
  import pujog_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic [7:0]  addr       = 8'h00;
  logic [31:0] wdat       = 32'h00000000;
  logic        wr_en      = 1'b0;
  logic        rd_en      = 1'b0;
  logic        clr        = 1'b0;
  logic [31:0] rdat;
  logic [31:0] pu_map;
  logic [31:0] four_map;
  logic [3:0]  pulse;
  logic [3:0]  dir;
  logic [4:0]  slot_sel;
  logic        active;
  logic        fault;
  logic [7:0]  code;
  logic        irq;
  logic [15:0] edges;
  int          error_cnt   = 0;
  int          check_count = 0;
  logic [31:0] d;

  pujog_jog_output dut_u (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wr_data_in(wdat), .wr_en_in(wr_en), .rd_en_in(rd_en),
    .rd_data_out(rdat), .slot_is_pu_in(pu_map),
    .slot_four_axis_in(four_map), .pulse_out(pulse), .dir_out(dir),
    .slot_sel_out(slot_sel), .active_flag_out(active),
    .fault_flag_out(fault), .fault_code_out(code), .irq_out(irq));

  pujog_bus_model bus_u (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clr_in(clr),
    .pulse_in(pulse), .slot_is_pu_out(pu_map),
    .slot_four_axis_out(four_map), .edge_cnt_out(edges));

  // Free-running 125 MHz clock.
  initial begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    wr_en <= 1'b1;
    addr  <= a;
    wdat  <= v;
    @(posedge ref_clk_in);
    wr_en <= 1'b0;
  endtask : wr

  // One-cycle register read; data is taken in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_in);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge ref_clk_in);
    rd_en <= 1'b0;
    #1 v = rdat;
  endtask : rd

  // Loads slot, axis and frequency, then requests the run.
  task automatic start(input logic [7:0] s, input logic [15:0] ax,
                       input logic [31:0] f);
    wr(PUJOG_OFS_SLOT, {24'h000000, s});
    wr(PUJOG_OFS_AXIS, {16'h0000, ax});
    wr(PUJOG_OFS_FREQ, f);
    wr(PUJOG_OFS_CTRL, 32'h00000001);
    repeat (3) @(posedge ref_clk_in);
    #1 `CHK("active", 1'b1, active);
  endtask : start

  // Drops the run, waits three cycles, then checks that active, fault, code and pulses are clear.
  task automatic stop();
    wr(PUJOG_OFS_CTRL, 32'h00000000);
    repeat (3) @(posedge ref_clk_in);
    #1 `CHK("active_off", 1'b0, active);
    `CHK("fault_off", 1'b0, fault);
    `CHK("code_off", PUJOG_FC_NONE, code);
    `CHK("pulse_off", 4'h0, pulse);
  endtask : stop

  // Counts edges over a window and checks them against the set rate.
  task automatic rate(input longint f);
    longint ex;
    longint got;
    @(posedge ref_clk_in) clr <= 1'b1;
    @(posedge ref_clk_in) clr <= 1'b0;
    repeat (16000) @(posedge ref_clk_in);
    #1 got = longint'(edges);
    ex = (f * 16000) / 125000000;
    `CHK("pulse_rate", 1'b1, (got >= ex - 1) && (got <= ex + 1));
  endtask : rate

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog cuts a hang short.
  initial begin
    repeat (80000) @(posedge ref_clk_in);
    error_cnt++;
    report_and_stop();
  end

  // Fault table: slot, axis, frequency and the code it must give.
  logic [7:0]  t_slot [7] = '{8'h20, 8'h00, 8'h06, 8'h04, 8'h04, 8'h06,
                             8'h06};
  logic [15:0] t_axis [7] = '{16'h1, 16'h1, 16'h3, 16'h5, 16'h1, 16'h1,
                             16'h2};
  logic [31:0] t_freq [7] = '{32'h10, 32'h10, 32'h10, 32'h10, 32'h000186A1,
                             32'hFFFCF2BF, 32'hFFFCF2C0};
  logic [7:0]  t_code [7] = '{8'h01, 8'h02, 8'h03, 8'h03, 8'h04, 8'h04,
                             8'h00};

  // Main sequence.
  initial begin
    longint f;
    void'($urandom(70));
    repeat (8) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    rd(PUJOG_OFS_AXIS, d);
    `CHK("axis_rst", 32'h1, d);
    rd(PUJOG_OFS_FREQ, d);
    `CHK("freq_rst", 32'h0, d);
    rd(8'h3C, d);
    `CHK("unmapped", 32'h0, d);
    $display("test reset done");
    wr(PUJOG_OFS_IRQ_MASK, 32'h7);
    f = 1 + ($urandom % 200000);
    start(8'h06, 16'h2, 32'(f));
    `CHK("no_fault", 1'b0, fault);
    `CHK("slot_sel", 5'h06, slot_sel);
    `CHK("irq_start", 1'b1, irq);
    rd(PUJOG_OFS_IRQ_STAT, d);
    `CHK("irq_stat", 32'h1, d);
    `CHK("irq_clr", 1'b0, irq);
    `CHK("dir_pos", 4'h0, dir);
    rate(f);
    stop();
    $display("test positive done");
    f = 1 + ($urandom % 100000);
    start(8'h04, 16'h3, 32'(-f));
    `CHK("dir_neg", 4'h4, dir);
    rate(f);
    stop();
    $display("test negative done");
    start(8'h05, 16'h4, 32'h0);
    rate(0);
    // A value pushed out of range while running must fault at once.
    wr(PUJOG_OFS_FREQ, 32'h000186A1);
    repeat (2) @(posedge ref_clk_in);
    #1 `CHK("run_fault", 1'b1, fault);
    `CHK("run_code", PUJOG_FC_FREQ, code);
    `CHK("run_no_pulse", 4'h0, pulse);
    stop();
    $display("test zero done");
    for (int i = 0; i < 7; i++) begin
      start(t_slot[i], t_axis[i], t_freq[i]);
      `CHK("fault", t_code[i] != 8'h00, fault);
      `CHK("code", t_code[i], code);
      rd(PUJOG_OFS_STAT, d);
      `CHK("stat", {t_code[i], 6'h00, t_code[i] != 8'h00, 1'b1}, d[15:0]);
      if (t_code[i] != 8'h00) begin
        `CHK("no_pulse", 4'h0, pulse | dir);
      end
      stop();
    end
    $display("test faults done");
    wr(PUJOG_OFS_IRQ_MASK, 32'h0);
    #1 `CHK("irq_masked", 1'b0, irq);
    rd(PUJOG_OFS_IRQ_STAT, d);
    `CHK("irq_bits", 32'h7, d);
    $display("test irq done");
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
